// file: asc_seq_ctrl.sv
// converter sequence control: apb registers, sample/convert sequencing, interrupt
//
// The address map and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "asc_defines.svh"

module asc_seq_ctrl #(
   parameter int RES_W = 10,
   parameter int DEPTH = 16
) (
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [`ASC_ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic conv_done,
   input wire logic [RES_W-1:0] conv_result,
   input wire logic ext_trigger_pin,
   output asc_pkg::asc_conv_ctrl_t conv_ctrl,
   output logic irq
);
   asc_pkg::asc_state_t state_q;
   logic converter_on_q;
   logic [2:0] trig_src_q;
   logic auto_sample_q;
   logic sample_active_q;
   logic done_q;
   logic conv_start_q;
   logic [2:0] reference_select_q;
   logic rsvd_q;
   logic scan_inputs_enable_q;
   logic [3:0] interrupt_pacing_count_q;
   logic split_buffer_mode_q;
   logic alternate_mux_mode_q;
   logic [`ASC_IRQ_W-1:0] ist_q;
   logic [`ASC_IRQ_W-1:0] imask_q;
   logic [`ASC_CH_W-1:0] mux_a_q;
   logic [`ASC_CH_W-1:0] mux_b_q;
   logic [`ASC_SCAN_W-1:0] scan_mask_q;
   logic [3:0] scan_pos_q;
   logic use_b_q;
   logic [`ASC_CH_W-1:0] mux_channel_q;
   logic ref_pos_q;
   logic ref_neg_q;
   logic [3:0] pace_cnt_q;
   logic irq_q;
   logic [31:0] prdata_q;
   logic pready_q;
   logic pslverr_q;
   logic trig_s1_q;
   logic trig_s2_q;
   logic trig_s3_q;

   logic acc, wr, rd, mapped, in_buf;
   logic wr_c1, wr_c2, sample_active_set, sample_active_clr;
   logic trig_edge, end_sample, conv_evt, seq_end, sample_active_start, clr_seq;
   logic [RES_W-1:0] buf_rd_data;
   logic fill_half;
   logic [3:0] scan_pick;
   logic [`ASC_IRQ_W-1:0] irq_evt;

   // first set bit of the scan mask at or after the given position, wrapping
   function automatic logic [3:0] next_scan(input logic [`ASC_SCAN_W-1:0] mask,
                                            input logic [3:0] from);
      logic [3:0] idx;
      logic [3:0] res;
      logic found;
      res = 4'h0;
      found = 1'b0;
      for (int i = 0; i < `ASC_SCAN_W; i++)
      begin
         idx = from + 4'(i);
         if (!found && mask[idx])
         begin
            res = idx;
            found = 1'b1;
         end
      end
      return res;
   endfunction : next_scan

   // apb: one wait cycle, answer registered
   assign acc = psel && penable && !pready_q;
   assign wr = acc && pwrite;
   assign rd = acc && !pwrite;
   assign in_buf = (paddr >= `ASC_OFF_BUF) && (paddr < (`ASC_OFF_BUF + `ASC_BUF_SPAN));
   assign mapped = (paddr[1:0] == 2'h0) &&
                   (in_buf || paddr == `ASC_OFF_CTRL1 || paddr == `ASC_OFF_CTRL2 ||
                    paddr == `ASC_OFF_ISTAT || paddr == `ASC_OFF_IMASK ||
                    paddr == `ASC_OFF_CHSEL || paddr == `ASC_OFF_SCAN);
   assign wr_c1 = wr && paddr == `ASC_OFF_CTRL1;
   assign wr_c2 = wr && paddr == `ASC_OFF_CTRL2;
   assign sample_active_set = wr_c1 && pwdata[`ASC_C1_SAMPLE_ACTIVE];
   assign sample_active_clr = wr_c1 && !pwdata[`ASC_C1_SAMPLE_ACTIVE];

   // the trigger pin comes from outside; the edge detector compares stages two and three
   assign trig_edge = trig_s2_q && !trig_s3_q;
   assign end_sample = (trig_src_q == `ASC_TRIG_MANUAL) ? sample_active_clr : trig_edge;
   assign conv_evt = converter_on_q && state_q == asc_pkg::ASC_CONVERT && conv_done;
   assign seq_end = conv_evt && pace_cnt_q == interrupt_pacing_count_q;
   assign sample_active_start = converter_on_q &&
                       ((state_q == asc_pkg::ASC_IDLE && sample_active_set) ||
                        state_q == asc_pkg::ASC_REARM);
   assign clr_seq = !converter_on_q ||
                    (wr_c2 && (pwdata[`ASC_C2_INTERRUPT_PACING_COUNT] != interrupt_pacing_count_q ||
                               pwdata[`ASC_C2_SPLIT_BUFFER_MODE] != split_buffer_mode_q));
   assign irq_evt = {conv_evt, seq_end};
   assign scan_pick = next_scan(scan_mask_q, scan_pos_q);

   always_ff @(posedge mclk)
   begin
      if (!rst_b)
      begin
         trig_s1_q <= 1'b0;
         trig_s2_q <= 1'b0;
         trig_s3_q <= 1'b0;
      end
      else
      begin
         trig_s1_q <= ext_trigger_pin;
         trig_s2_q <= trig_s1_q;
         trig_s3_q <= trig_s2_q;
      end
   end

   // software-owned control fields
   always_ff @(posedge mclk)
   begin
      if (!rst_b)
      begin
         converter_on_q <= 1'b0;
         trig_src_q <= `ASC_TRIG_MANUAL;
         auto_sample_q <= 1'b0;
         reference_select_q <= `ASC_RST_REFERENCE_SELECT;
         rsvd_q <= 1'b0;
         scan_inputs_enable_q <= 1'b0;
         interrupt_pacing_count_q <= `ASC_RST_INTERRUPT_PACING_COUNT;
         split_buffer_mode_q <= 1'b0;
         alternate_mux_mode_q <= 1'b0;
         imask_q <= `ASC_RST_IRQ;
         mux_a_q <= `ASC_RST_CH;
         mux_b_q <= `ASC_RST_CH;
         scan_mask_q <= `ASC_RST_MASK;
      end
      else
      begin
         if (wr_c1)
         begin
            converter_on_q <= pwdata[`ASC_C1_ON];
            trig_src_q <= pwdata[`ASC_C1_TRIG];
            auto_sample_q <= pwdata[`ASC_C1_AUTO];
         end
         if (wr_c2)
         begin
            reference_select_q <= pwdata[`ASC_C2_REFERENCE_SELECT];
            rsvd_q <= pwdata[`ASC_C2_RSVD];
            scan_inputs_enable_q <= pwdata[`ASC_C2_SCAN];
            interrupt_pacing_count_q <= pwdata[`ASC_C2_INTERRUPT_PACING_COUNT];
            split_buffer_mode_q <= pwdata[`ASC_C2_SPLIT_BUFFER_MODE];
            alternate_mux_mode_q <= pwdata[`ASC_C2_ALTERNATE_MUX_MODE];
         end
         if (wr && paddr == `ASC_OFF_IMASK)
            imask_q <= pwdata[`ASC_IRQ_W-1:0];
         if (wr && paddr == `ASC_OFF_CHSEL)
         begin
            mux_a_q <= pwdata[`ASC_CH_A];
            mux_b_q <= pwdata[`ASC_CH_B];
         end
         if (wr && paddr == `ASC_OFF_SCAN)
            scan_mask_q <= pwdata[`ASC_SCAN_W-1:0];
      end
   end

   // sample/convert sequencer; sample flag is software-writable only outside conversion
   always_ff @(posedge mclk)
   begin
      if (!rst_b)
      begin
         state_q <= asc_pkg::ASC_IDLE;
         sample_active_q <= 1'b0;
         done_q <= 1'b0;
         conv_start_q <= 1'b0;
      end
      else
      begin
         conv_start_q <= 1'b0;
         if (!converter_on_q)
         begin
            state_q <= asc_pkg::ASC_IDLE;
            sample_active_q <= 1'b0;
         end
         else
         begin
            unique case (state_q)
               asc_pkg::ASC_IDLE:
                  if (sample_active_set)
                  begin
                     state_q <= asc_pkg::ASC_SAMPLE;
                     sample_active_q <= 1'b1;
                     done_q <= 1'b0;
                  end
               asc_pkg::ASC_SAMPLE:
                  if (end_sample)
                  begin
                     state_q <= asc_pkg::ASC_CONVERT;
                     sample_active_q <= 1'b0;
                     conv_start_q <= 1'b1;
                  end
               asc_pkg::ASC_CONVERT:
                  if (conv_done)
                  begin
                     done_q <= 1'b1;
                     state_q <= auto_sample_q ? asc_pkg::ASC_REARM : asc_pkg::ASC_IDLE;
                  end
               asc_pkg::ASC_REARM:
               begin
                  state_q <= asc_pkg::ASC_SAMPLE;
                  sample_active_q <= 1'b1;
                  done_q <= 1'b0;
               end
            endcase
         end
      end
   end

   // channel chosen at each sample start; scan and alternation restart per interrupt
   always_ff @(posedge mclk)
   begin
      if (!rst_b)
      begin
         mux_channel_q <= `ASC_RST_CH;
         scan_pos_q <= 4'h0;
         use_b_q <= 1'b0;
      end
      else if (clr_seq || seq_end)
      begin
         scan_pos_q <= 4'h0;
         use_b_q <= 1'b0;
      end
      else if (sample_active_start)
      begin
         if (alternate_mux_mode_q && use_b_q)
            mux_channel_q <= mux_b_q;
         else if (scan_inputs_enable_q)
         begin
            mux_channel_q <= `ASC_CH_W'(scan_pick);
            scan_pos_q <= scan_pick + 4'h1;
         end
         else
            mux_channel_q <= mux_a_q;
         use_b_q <= alternate_mux_mode_q && !use_b_q;
      end
   end

   always_ff @(posedge mclk)
   begin
      if (!rst_b)
      begin
         ref_pos_q <= 1'b0;
         ref_neg_q <= 1'b0;
      end
      else
      begin
         ref_pos_q <= reference_select_q == `ASC_REFERENCE_SELECT_POS ||
                      reference_select_q == `ASC_REFERENCE_SELECT_BOTH;
         ref_neg_q <= reference_select_q == `ASC_REFERENCE_SELECT_NEG ||
                      reference_select_q == `ASC_REFERENCE_SELECT_BOTH;
      end
   end

   always_ff @(posedge mclk)
   begin
      if (!rst_b || clr_seq)
         pace_cnt_q <= 4'h0;
      else if (seq_end)
         pace_cnt_q <= 4'h0;
      else if (conv_evt)
         pace_cnt_q <= pace_cnt_q + 4'h1;
   end

   // sticky status, write one to clear; a same-cycle event wins
   always_ff @(posedge mclk)
   begin
      if (!rst_b)
      begin
         ist_q <= `ASC_RST_IRQ;
         irq_q <= 1'b0;
      end
      else
      begin
         if (wr && paddr == `ASC_OFF_ISTAT)
            ist_q <= (ist_q & ~pwdata[`ASC_IRQ_W-1:0]) | irq_evt;
         else
            ist_q <= ist_q | irq_evt;
         irq_q <= |(ist_q & imask_q);
      end
   end

   asc_result_buf #(
      .RES_W(RES_W),
      .DEPTH(DEPTH)
   ) u_buf (
      .mclk(mclk),
      .rst_b(rst_b),
      .clear(clr_seq),
      .split(split_buffer_mode_q),
      .wr_en(conv_evt),
      .wr_data(conv_result),
      .seq_end(seq_end),
      .rd_idx(paddr[`ASC_BUF_IDX]),
      .rd_data(buf_rd_data),
      .fill_half(fill_half)
   );

   always_ff @(posedge mclk)
   begin
      if (!rst_b)
      begin
         prdata_q <= 32'h0000_0000;
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
      end
      else
      begin
         pready_q <= acc;
         pslverr_q <= acc && !mapped;
         if (rd)
         begin
            prdata_q <= 32'h0000_0000;
            if (in_buf && mapped)
               prdata_q[RES_W-1:0] <= buf_rd_data;
            else if (paddr == `ASC_OFF_CTRL1)
            begin
               prdata_q[`ASC_C1_ON] <= converter_on_q;
               prdata_q[`ASC_C1_TRIG] <= trig_src_q;
               prdata_q[`ASC_C1_AUTO] <= auto_sample_q;
               prdata_q[`ASC_C1_SAMPLE_ACTIVE] <= sample_active_q;
               prdata_q[`ASC_C1_DONE] <= done_q;
            end
            else if (paddr == `ASC_OFF_CTRL2)
            begin
               prdata_q[`ASC_C2_REFERENCE_SELECT] <= reference_select_q;
               prdata_q[`ASC_C2_RSVD] <= rsvd_q;
               prdata_q[`ASC_C2_SCAN] <= scan_inputs_enable_q;
               prdata_q[`ASC_C2_FILL_HALF_INDICATOR] <= fill_half;
               prdata_q[`ASC_C2_INTERRUPT_PACING_COUNT] <= interrupt_pacing_count_q;
               prdata_q[`ASC_C2_SPLIT_BUFFER_MODE] <= split_buffer_mode_q;
               prdata_q[`ASC_C2_ALTERNATE_MUX_MODE] <= alternate_mux_mode_q;
            end
            else if (paddr == `ASC_OFF_ISTAT)
               prdata_q[`ASC_IRQ_W-1:0] <= ist_q;
            else if (paddr == `ASC_OFF_IMASK)
               prdata_q[`ASC_IRQ_W-1:0] <= imask_q;
            else if (paddr == `ASC_OFF_CHSEL)
            begin
               prdata_q[`ASC_CH_A] <= mux_a_q;
               prdata_q[`ASC_CH_B] <= mux_b_q;
            end
            else if (paddr == `ASC_OFF_SCAN)
               prdata_q[`ASC_SCAN_W-1:0] <= scan_mask_q;
         end
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign irq = irq_q;
   assign conv_ctrl = '{sh_track: sample_active_q, conv_start: conv_start_q,
                        ref_pos_ext: ref_pos_q, ref_neg_ext: ref_neg_q,
                        mux_channel: mux_channel_q};

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_b);

   sequence s_conv_end;
      conv_evt;
   endsequence
   sequence s_rearm;
      state_q == asc_pkg::ASC_REARM ##1 sample_active_q && !done_q;
   endsequence

   chk_track_hold: assert property (
      (state_q == asc_pkg::ASC_SAMPLE) == conv_ctrl.sh_track)
      else $error("sample flag does not match sampling phase");
   chk_done_set: assert property (
      s_conv_end |=> done_q)
      else $error("done flag not set after conversion end");
   chk_buf_dropped: assert property (
      !converter_on_q |=> !fill_half && u_buf.wp_q == '0)
      else $error("buffer state kept while converter off");
   chk_ref_decode: assert property (
      $stable(reference_select_q) [*2] |->
      ref_pos_q == (reference_select_q == `ASC_REFERENCE_SELECT_POS || reference_select_q == `ASC_REFERENCE_SELECT_BOTH) &&
      ref_neg_q == (reference_select_q == `ASC_REFERENCE_SELECT_NEG || reference_select_q == `ASC_REFERENCE_SELECT_BOTH))
      else $error("reference pins do not follow reference select");
   chk_mux_a_only: assert property (
      sample_active_start && !clr_seq && !alternate_mux_mode_q && !scan_inputs_enable_q
      |=> mux_channel_q == $past(mux_a_q))
      else $error("mux A setting not used");
   chk_scan_pick: assert property (
      sample_active_start && !clr_seq && !seq_end && scan_inputs_enable_q && !use_b_q &&
      scan_mask_q != '0 |=> scan_mask_q[mux_channel_q[3:0]])
      else $error("scan picked an unselected input");
   chk_alt_b: assert property (
      sample_active_start && !clr_seq && !seq_end && alternate_mux_mode_q && use_b_q
      |=> mux_channel_q == $past(mux_b_q) && !use_b_q)
      else $error("alternate sample did not use mux B");
   chk_half_swap: assert property (
      seq_end && split_buffer_mode_q && !clr_seq |=> fill_half != $past(fill_half))
      else $error("fill half did not swap at interrupt");
   chk_pace_count: assert property (
      seq_end |-> conv_evt && pace_cnt_q == interrupt_pacing_count_q ##1 pace_cnt_q == 4'h0)
      else $error("pacing interrupt at wrong sequence");
   chk_manual_end: assert property (
      converter_on_q && state_q == asc_pkg::ASC_SAMPLE && trig_src_q == `ASC_TRIG_MANUAL &&
      sample_active_clr
      |=> conv_ctrl.conv_start && state_q == asc_pkg::ASC_CONVERT ##1 !conv_ctrl.conv_start)
      else $error("clearing sample flag did not start conversion");
   chk_auto_rearm: assert property (
      s_conv_end and auto_sample_q |=> s_rearm)
      else $error("sampling did not restart after conversion");
   chk_ctrl2_zero: assert property (
      rd && paddr == `ASC_OFF_CTRL2 |=> prdata[11] == 1'b0 && prdata[9:8] == 2'h0 &&
      prdata[6] == 1'b0 && prdata[31:16] == 16'h0000)
      else $error("unimplemented bits read nonzero");
   chk_done_clear: assert property (
      sample_active_start |=> !done_q)
      else $error("done flag kept into new sampling");

endmodule : asc_seq_ctrl
`default_nettype wire

// file: asc_defines.svh
// register offsets, field positions and reset values of the converter sequence control
`ifndef ASC_DEFINES_SVH
`define ASC_DEFINES_SVH

`define ASC_ADDR_W 8
`define ASC_OFF_CTRL1 8'h00
`define ASC_OFF_CTRL2 8'h04
`define ASC_OFF_ISTAT 8'h08
`define ASC_OFF_IMASK 8'h0C
`define ASC_OFF_CHSEL 8'h10
`define ASC_OFF_SCAN 8'h14
`define ASC_OFF_BUF 8'h40
`define ASC_BUF_SPAN 8'h40
`define ASC_BUF_IDX 5:2

`define ASC_C1_ON 15
`define ASC_C1_TRIG 7:5
`define ASC_C1_AUTO 2
`define ASC_C1_SAMPLE_ACTIVE 1
`define ASC_C1_DONE 0
`define ASC_TRIG_MANUAL 3'h0

`define ASC_C2_REFERENCE_SELECT 15:13
`define ASC_C2_RSVD 12
`define ASC_C2_SCAN 10
`define ASC_C2_FILL_HALF_INDICATOR 7
`define ASC_C2_INTERRUPT_PACING_COUNT 5:2
`define ASC_C2_SPLIT_BUFFER_MODE 1
`define ASC_C2_ALTERNATE_MUX_MODE 0
`define ASC_REFERENCE_SELECT_INT 3'h0
`define ASC_REFERENCE_SELECT_POS 3'h1
`define ASC_REFERENCE_SELECT_NEG 3'h2
`define ASC_REFERENCE_SELECT_BOTH 3'h3

`define ASC_IRQ_PACE 0
`define ASC_IRQ_CONV 1
`define ASC_IRQ_W 2

`define ASC_CH_A 4:0
`define ASC_CH_B 12:8
`define ASC_CH_W 5
`define ASC_SCAN_W 16

`define ASC_RST_REFERENCE_SELECT 3'h0
`define ASC_RST_INTERRUPT_PACING_COUNT 4'h0
`define ASC_RST_CH 5'h00
`define ASC_RST_MASK 16'h0000
`define ASC_RST_IRQ 2'h0

`endif

// file: asc_pkg.sv
// types shared by the converter sequence control
`default_nettype none
package asc_pkg;

   typedef enum logic [1:0] {
      ASC_IDLE,
      ASC_SAMPLE,
      ASC_CONVERT,
      ASC_REARM
   } asc_state_t;

   typedef struct packed {
      logic sh_track;
      logic conv_start;
      logic ref_pos_ext;
      logic ref_neg_ext;
      logic [4:0] mux_channel;
   } asc_conv_ctrl_t;

endpackage : asc_pkg
`default_nettype wire

// file: asc_result_buf.sv
// result buffer with single or split-half fill and write pointer
`timescale 1ns/1ps
`default_nettype none
`include "asc_defines.svh"

module asc_result_buf #(
   parameter int RES_W = 10,
   parameter int DEPTH = 16
) (
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic clear,
   input wire logic split,
   input wire logic wr_en,
   input wire logic [RES_W-1:0] wr_data,
   input wire logic seq_end,
   input wire logic [$clog2(DEPTH)-1:0] rd_idx,
   output logic [RES_W-1:0] rd_data,
   output logic fill_half
);
   localparam int AW = $clog2(DEPTH);

   logic [RES_W-1:0] mem_q [DEPTH];
   logic [AW-1:0] wp_q;
   logic half_q;
   logic [AW-1:0] wr_addr;

   // split mode keeps the top address bit on the half being filled
   assign wr_addr = split ? {half_q, wp_q[AW-2:0]} : wp_q;
   assign rd_data = mem_q[rd_idx];
   assign fill_half = half_q;

   // contents are dropped on clear: results do not survive a disable
   always_ff @(posedge mclk)
   begin
      if (!rst_b || clear)
      begin
         for (int i = 0; i < DEPTH; i++)
            mem_q[i] <= '0;
      end
      else if (wr_en)
         mem_q[wr_addr] <= wr_data;
   end

   always_ff @(posedge mclk)
   begin
      if (!rst_b || clear)
      begin
         wp_q <= '0;
         half_q <= 1'b0;
      end
      else if (wr_en && seq_end)
      begin
         wp_q <= '0;
         if (split)
            half_q <= ~half_q;
      end
      else if (wr_en)
         wp_q <= wp_q + AW'(1);
   end

endmodule : asc_result_buf
`default_nettype wire

// file: asc_conv_model.sv
// behavioural converter on the analog side: holds the tracked channel and answers after a delay
`timescale 1ns/1ps
`default_nettype none

module asc_conv_model (
   input wire logic mclk,
   input wire logic rst_b,
   input wire asc_pkg::asc_conv_ctrl_t ctrl,
   input wire logic [3:0] lat,
   output logic conv_done,
   output logic [9:0] conv_result
);
   logic busy_q;
   logic [3:0] wait_q;
   logic [4:0] cnt_q;
   logic [4:0] ch_q;

   always_ff @(posedge mclk)
   begin
      if (!rst_b)
      begin
         busy_q <= 1'b0;
         wait_q <= 4'h0;
         cnt_q <= 5'h00;
         ch_q <= 5'h00;
         conv_done <= 1'b0;
         conv_result <= 10'h3FF;
      end
      else
      begin
         conv_done <= 1'b0;
         // result lines are not valid outside the done pulse, so they keep toggling
         conv_result <= ~conv_result;
         if (ctrl.sh_track)
            ch_q <= ctrl.mux_channel;
         if (ctrl.conv_start)
         begin
            busy_q <= 1'b1;
            wait_q <= lat;
         end
         else if (busy_q && wait_q == 4'h0)
         begin
            busy_q <= 1'b0;
            conv_done <= 1'b1;
            conv_result <= {cnt_q, ch_q};
            cnt_q <= cnt_q + 5'h01;
         end
         else if (busy_q)
            wait_q <= wait_q - 4'h1;
      end
   end
endmodule : asc_conv_model

`default_nettype wire

// file: asc_seq_ctrl_tb.sv
// self-checking bench of the converter sequence control
`timescale 1ns/1ps
`default_nettype none
`include "asc_defines.svh"

module asc_seq_ctrl_tb;
   logic mclk, rst_b, psel, penable, pwrite, pready, pslverr, conv_done, irq, er, trig;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd, msk;
   logic [31:0] s = 32'h000047F7;
   logic [9:0] conv_result;
   logic [3:0] lat;
   asc_pkg::asc_conv_ctrl_t conv_ctrl;
   int failures = 0, samples_checked = 0;
   int conv_n = 0, ptr, half, seqs, n_p, spl, alt;

   asc_seq_ctrl #(.RES_W(10), .DEPTH(16)) dut (.mclk(mclk), .rst_b(rst_b), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .conv_done(conv_done), .conv_result(conv_result),
      .ext_trigger_pin(trig), .conv_ctrl(conv_ctrl), .irq(irq));
   asc_conv_model partner (.mclk(mclk), .rst_b(rst_b), .ctrl(conv_ctrl), .lat(lat),
      .conv_done(conv_done), .conv_result(conv_result));

   function automatic logic [31:0] rnd();
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      s = s ^ (s << 5);
      return s;
   endfunction : rnd

   task automatic close_out();
      $display("checked %0d mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : close_out

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      samples_checked++;
      if (g !== e)
      begin
         failures++;
         $display("mismatch at %0t: got %0h exp %0h", $time, g, e);
      end
   endtask : chk

   // the master never assumes a latency: it waits for pready under a bound
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge mclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do
      begin
         @(posedge mclk);
         n++;
      end
      while (pready !== 1'b1 && n < 50);
      if (n >= 50)
         failures++;
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic conv();
      logic [4:0] ch;
      logic pace;
      int n, slot;
      ch = (alt != 0 && seqs % 2 == 1) ? 5'h09 : 5'h05;
      pace = (seqs == n_p);
      slot = (spl != 0) ? half * 8 + ptr : ptr;
      lat <= 4'(rnd() % 32'h7);
      apb(1'b1, `ASC_OFF_CTRL1, 32'h00008002);
      apb(1'b0, `ASC_OFF_CTRL1, 32'h0);
      chk(rd & 32'h3, 32'h2);
      chk(32'(conv_ctrl.sh_track), 32'h1);
      chk(32'(conv_ctrl.mux_channel), 32'(ch));
      apb(1'b1, `ASC_OFF_CTRL1, 32'h00008000);
      n = 0;
      do
      begin
         apb(1'b0, `ASC_OFF_CTRL1, 32'h0);
         n++;
      end
      while (rd[0] !== 1'b1 && n < 20);
      chk(rd & 32'h3, 32'h1);
      chk(32'(conv_ctrl.sh_track), 32'h0);
      apb(1'b0, `ASC_OFF_ISTAT, 32'h0);
      chk(rd, {30'h0, 1'b1, pace});
      chk(32'(irq), 32'((pace & msk[0]) | msk[1]));
      apb(1'b0, 8'(`ASC_OFF_BUF + slot * 4), 32'h0);
      chk(rd, 32'({conv_n[4:0], ch}));
      conv_n++;
      ptr++;
      seqs++;
      if (pace)
      begin
         seqs = 0;
         ptr = 0;
         half = half ^ spl;
      end
      apb(1'b0, `ASC_OFF_CTRL2, 32'h0);
      if (spl != 0)
         chk(32'(rd[7]), 32'(half));
      apb(1'b1, `ASC_OFF_ISTAT, 32'h3);
      apb(1'b0, `ASC_OFF_ISTAT, 32'h0);
      chk(rd | 32'(irq), 32'h0);
   endtask : conv

   // pin trigger ends sampling; auto start resumes on the next scanned input
   task automatic trig_conv(input logic [4:0] ch, input int slot);
      int n;
      n = 0;
      chk(32'({conv_ctrl.sh_track, conv_ctrl.mux_channel}), 32'({1'b1, ch}));
      @(posedge mclk);
      trig <= 1'b1;
      repeat (4) @(posedge mclk);
      trig <= 1'b0;
      do
      begin
         apb(1'b0, `ASC_OFF_ISTAT, 32'h0);
         n++;
      end
      while (rd[1] !== 1'b1 && n < 20);
      chk(rd, 32'({1'b1, slot == 1}));
      apb(1'b1, `ASC_OFF_ISTAT, 32'h3);
      apb(1'b0, 8'(`ASC_OFF_BUF + slot * 4), 32'h0);
      chk(rd, 32'({conv_n[4:0], ch}));
      conv_n++;
   endtask : trig_conv

   initial
   begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end

   initial
   begin
      #1000000;
      failures++;
      close_out();
   end

   initial
   begin
      rst_b = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      lat = 4'h0;
      trig = 1'b0;
      repeat (10) @(posedge mclk);
      rst_b <= 1'b1;
      apb(1'b0, `ASC_OFF_CTRL2, 32'h0);
      chk(rd, 32'h0);
      apb(1'b1, `ASC_OFF_CTRL2, 32'h00000BC0);
      apb(1'b0, `ASC_OFF_CTRL2, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, 8'h20, 32'h0);
      chk({er, rd[30:0]}, 32'h80000000);
      apb(1'b0, 8'h80, 32'h0);
      chk({er, rd[30:0]}, 32'h80000000);
      for (int v = 0; v < 8; v++)
      begin
         apb(1'b1, `ASC_OFF_CTRL2, 32'(v) << 13);
         apb(1'b0, `ASC_OFF_CTRL2, 32'h0);
         chk(rd, 32'(v) << 13);
         chk(32'({conv_ctrl.ref_pos_ext, conv_ctrl.ref_neg_ext}),
             32'({v == 1 || v == 3, v == 2 || v == 3}));
      end
      apb(1'b1, `ASC_OFF_CHSEL, 32'h00000905);
      for (int i = 0; i < 4; i++)
      begin
         msk = 32'(i);
         n_p = int'(rnd() % 32'h4);
         spl = int'(rnd() % 32'h2);
         alt = int'(rnd() % 32'h2);
         apb(1'b1, `ASC_OFF_IMASK, msk);
         apb(1'b1, `ASC_OFF_CTRL1, 32'h0);
         apb(1'b0, `ASC_OFF_BUF, 32'h0);
         chk(rd, 32'h0);
         apb(1'b1, `ASC_OFF_CTRL1, 32'h00008000);
         apb(1'b1, `ASC_OFF_CTRL2, 32'((n_p << 2) | (spl << 1) | alt));
         ptr = 0;
         half = 0;
         seqs = 0;
         repeat (2 * n_p + 3) conv();
      end
      // scan over inputs 3 and 5, pin trigger, auto start, interrupt every second sequence
      apb(1'b1, `ASC_OFF_CTRL1, 32'h0);
      apb(1'b1, `ASC_OFF_SCAN, 32'h00000028);
      apb(1'b1, `ASC_OFF_CTRL1, 32'h00008024);
      apb(1'b1, `ASC_OFF_CTRL2, 32'h00000404);
      apb(1'b1, `ASC_OFF_CTRL1, 32'h00008026);
      for (int k = 0; k < 4; k++)
         trig_conv((k % 2 == 1) ? 5'h05 : 5'h03, k % 2);
      close_out();
   end
endmodule : asc_seq_ctrl_tb

`default_nettype wire
